// ==== dir_oc_front_end.sv ====
// measurement front end model, one fresh set per program tick
`timescale 1ns/1ps
module dir_oc_front_end import dir_oc_pkg::*; (
	// clock, reset and tick
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic program_tick_i,
	// analogue scene
	input wire logic [1:0] phase_i,
	input wire logic [15:0] rms_i,
	input wire logic [15:0] trms_i,
	input wire logic [15:0] peak_i,
	input wire logic [15:0] volt_i,
	input wire logic [11:0] vang_i,
	input wire logic [11:0] iang_i,
	input wire logic [1:0] fault_i,
	// measurement set
	output meas_t meas_o,
	output logic meas_valid_o
);
	// refresh on the tick, scramble between so stale data is never trusted
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			meas_o <= '0;
			meas_valid_o <= 1'b0;
		end else if (program_tick_i) begin
			meas_valid_o <= 1'b1;
			meas_o <= '0;
			meas_o.phase_rms[phase_i] <= rms_i;
			meas_o.phase_trms[phase_i] <= trms_i;
			meas_o.phase_peak[phase_i] <= peak_i;
			meas_o.positive_sequence_voltage <= volt_i;
			meas_o.line_to_line_voltage_mode <= fault_i != 2'h0;
			meas_o.single_phase_fault <= fault_i == 2'h1;
			meas_o.short_circuit <= fault_i == 2'h2;
			meas_o.voltage_angle <= (fault_i != 2'h0) ? 12'h3E8 : vang_i; // junk in line mode
			meas_o.current_angle <= (fault_i != 2'h0) ? 12'hC18 : iang_i;
			meas_o.healthy_ll_angle <= vang_i;
			meas_o.faulty_phase_angle <= iang_i;
			meas_o.impedance_angle <= iang_i - vang_i;
		end else begin
			meas_valid_o <= 1'b0;
			meas_o <= ~meas_o;
		end
	end
endmodule : dir_oc_front_end

// ==== dir_oc_pkg.sv ====
// shared constants, register map and carrier types of the directional overcurrent stage
package dir_oc_pkg;
	// program cycle and timing
	localparam int PROGRAM_CYCLE_US = 5000;
	localparam int CLOCK_KHZ = 25000;
	localparam int PROGRAM_CYCLE_CLKS = PROGRAM_CYCLE_US * CLOCK_KHZ / 1000;
	localparam int HISTORY_MS = 100;
	localparam int MEMORY_HOLD_MS = 500;
	localparam int HISTORY_TICKS = HISTORY_MS * 1000 / PROGRAM_CYCLE_US;
	localparam int MEMORY_HOLD_TICKS = MEMORY_HOLD_MS * 1000 / PROGRAM_CYCLE_US;
	// analogue figures: voltage in 0.01 V, angles in 0.1 deg, current in 0.01 x nominal
	localparam logic [15:0] VOLTAGE_LOSS_LEVEL = 16'h0064;
	localparam logic [7:0] RESET_RATIO_PCT = 8'h61;
	localparam logic [7:0] FULL_PCT = 8'h64;
	localparam logic signed [13:0] ANGLE_HALF_TURN = 14'sh0708;
	localparam logic signed [13:0] ANGLE_FULL_TURN = 14'sh0E10;
	localparam logic signed [13:0] SECTOR_HYSTERESIS = 14'sh0014;
	localparam logic [11:0] SECTOR_MIN = 12'h00A;
	localparam logic [11:0] SECTOR_MAX = 12'h6A4;
	localparam logic signed [11:0] CENTER_MIN = -12'sh708;
	localparam logic signed [11:0] CENTER_MAX = 12'sh708;
	localparam logic [15:0] THRESHOLD_MIN = 16'h000A;
	localparam logic [15:0] THRESHOLD_MAX = 16'h0FA0;
	// register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_GROUP_BASE = 8'h10;
	localparam logic [7:0] REG_GROUP_STRIDE = 8'h10;
	localparam logic [7:0] REG_THRESHOLD = 8'h00;
	localparam logic [7:0] REG_SECTOR_HALF = 8'h04;
	localparam logic [7:0] REG_SECTOR_CENTER = 8'h08;
	localparam logic [7:0] REG_OPERATE_DELAY = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h40;
	localparam logic [7:0] REG_ANGLE = 8'h44;
	localparam int GROUPS = 2;
	// control field positions
	localparam int CTRL_DIRECTIONAL = 0;
	localparam int CTRL_MAG_LO = 1;
	localparam int CTRL_FORCE_LO = 3;
	// reset values
	localparam logic [15:0] THRESHOLD_RESET = 16'h0078;
	localparam logic [11:0] SECTOR_HALF_RESET = 12'h370;
	localparam logic signed [11:0] SECTOR_CENTER_RESET = 12'sh000;
	localparam logic [15:0] OPERATE_DELAY_RESET = 16'h0000;

	typedef enum logic [1:0] {MAG_RMS, MAG_TRMS, MAG_PEAK} magnitude_t;
	typedef enum logic [1:0] {FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED} force_t;

	// one measurement set from the front end
	typedef struct packed {
		logic [2:0][15:0] phase_rms;
		logic [2:0][15:0] phase_trms;
		logic [2:0][15:0] phase_peak;
		logic [15:0] positive_sequence_voltage;
		logic signed [11:0] voltage_angle;
		logic signed [11:0] current_angle;
		logic signed [11:0] healthy_ll_angle;
		logic signed [11:0] faulty_phase_angle;
		logic signed [11:0] impedance_angle;
		logic line_to_line_voltage_mode;
		logic residual_voltage_present;
		logic single_phase_fault;
		logic short_circuit;
	} meas_t;

	// settings taken from the active group
	typedef struct packed {
		logic [15:0] pickup_threshold;
		logic [11:0] sector_half;
		logic signed [11:0] sector_center;
		logic [15:0] operate_delay;
	} group_t;

	// stage outputs
	typedef struct packed {
		logic start;
		logic trip;
		logic blocked;
	} stage_out_t;
endpackage : dir_oc_pkg

// ==== dir_oc_stage.sv ====
// directional overcurrent stage with angle memory, sector test and definite delay
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Contract
// - select fundamental, true RMS or peak magnitude
// - refresh all measurement inputs each cycle
// - fault angle is current minus voltage angle
// - line-to-line mode uses healthy/faulty or impedance
// - below 1 V hold memory 0.5 s, then zero
// - memory equals angle 100 ms before fault
// - release below 97 % of threshold
// - one threshold, any phase exceeding picks up
// - directional or non-directional, directional default
// - non-directional ignores angle
// - directional needs angle inside sector
// - half-width 1.0 to 170.0, default 88
// - sector center offset rotates sector
// - 2 degree hysteresis leaving sector
// - threshold in 0.01 steps, default 1.20
// - force status applies only while forcing enabled
// - magnitude and force settings are static
// - group settings come from active group live
// - pick-up unblocked asserts start and timing
// - pick-up blocked asserts blocked, stops evaluation
module dir_oc_stage import dir_oc_pkg::*; #(
	parameter int CYCLE_CLKS = PROGRAM_CYCLE_CLKS
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_n_i,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [31:0] reg_rdata_o,
	// measurement front end
	input wire meas_t meas_i,
	input wire logic meas_valid_i,
	// system inputs
	input wire logic block_i,
	input wire logic stage_forcing_enable_i,
	input wire logic setting_group_i,
	// stage outputs
	output stage_out_t stage_o,
	output logic program_tick_o
);
	// angle helpers
	function automatic logic signed [11:0] wrap_angle(input logic signed [13:0] a);
		logic signed [13:0] r;
		r = a;
		if (r > ANGLE_HALF_TURN) begin
			r = r - ANGLE_FULL_TURN;
		end else if (r < -ANGLE_HALF_TURN) begin
			r = r + ANGLE_FULL_TURN;
		end
		return r[11:0];
	endfunction : wrap_angle
	function automatic logic signed [13:0] abs_angle(input logic signed [11:0] a);
		logic signed [13:0] r;
		r = 14'(a);
		return (r < 0) ? -r : r;
	endfunction : abs_angle
	function automatic logic [15:0] pick_mag(input meas_t m, input logic [1:0] sel, input int ph);
		logic [15:0] r;
		r = m.phase_rms[ph];
		case (sel)
			MAG_TRMS: r = m.phase_trms[ph];
			MAG_PEAK: r = m.phase_peak[ph];
			default: r = m.phase_rms[ph];
		endcase
		return r;
	endfunction : pick_mag

	// registers and state
	logic [$clog2(PROGRAM_CYCLE_CLKS+1)-1:0] div_count;
	logic tick;
	logic directional;
	logic [1:0] mag_select;
	logic [1:0] force_select;
	group_t group_bank [GROUPS];
	group_t active;
	meas_t meas;
	logic signed [11:0] history [HISTORY_TICKS];
	logic [4:0] hist_ptr;
	logic [7:0] mem_ticks;
	logic picked;
	logic in_sector;
	logic start;
	logic trip;
	logic blocked;
	logic [15:0] delay_count;
	logic signed [11:0] operating_angle;
	logic using_memory;
	logic angle_zeroed;

	// combinational results
	logic [2:0] above;
	logic [2:0] released;
	logic next_picked;
	logic voltage_lost;
	logic signed [11:0] live_ref;
	logic signed [11:0] ref_angle;
	logic signed [11:0] cur_angle;
	logic signed [11:0] next_angle;
	logic signed [13:0] sector_dist;
	logic next_in_sector;
	logic qualified;
	logic [ADDR_W-1:0] group_off;
	logic group_hit;
	logic group_wsel;

	// program cycle divider
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			div_count <= '0;
			tick <= 1'b0;
		end else if (div_count == ($bits(div_count))'(CYCLE_CLKS - 1)) begin
			div_count <= '0;
			tick <= 1'b1;
		end else begin
			div_count <= div_count + 1'b1;
			tick <= 1'b0;
		end
	end

	// latest measurement set
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			meas <= '0;
		end else if (meas_valid_i) begin
			meas <= meas_i;
		end
	end

	// register decode
	always_comb begin
		group_off = reg_addr_i - REG_GROUP_BASE;
		group_hit = (reg_addr_i >= REG_GROUP_BASE) && (reg_addr_i < REG_GROUP_BASE + 8'(GROUPS) * REG_GROUP_STRIDE);
		group_wsel = group_off[4];
	end

	// static settings, outside any group
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			directional <= 1'b1;
			mag_select <= MAG_RMS;
			force_select <= FORCE_NORMAL;
		end else if (reg_write_i && reg_addr_i == REG_CONTROL) begin
			directional <= reg_wdata_i[CTRL_DIRECTIONAL];
			mag_select <= reg_wdata_i[CTRL_MAG_LO +: 2];
			force_select <= reg_wdata_i[CTRL_FORCE_LO +: 2];
		end
	end

	// group settings, with range clamps on all but the operate delay
	generate
		for (genvar g = 0; g < GROUPS; g++) begin : g_bank
			always_ff @(posedge clock_i) begin
				if (!reset_n_i) begin
					group_bank[g].pickup_threshold <= THRESHOLD_RESET;
					group_bank[g].sector_half <= SECTOR_HALF_RESET;
					group_bank[g].sector_center <= SECTOR_CENTER_RESET;
					group_bank[g].operate_delay <= OPERATE_DELAY_RESET;
				end else if (reg_write_i && group_hit && group_wsel == 1'(g)) begin
					case (8'(group_off[3:0]))
						REG_THRESHOLD: begin
							if (reg_wdata_i[15:0] < THRESHOLD_MIN) begin
								group_bank[g].pickup_threshold <= THRESHOLD_MIN;
							end else if (reg_wdata_i[15:0] > THRESHOLD_MAX) begin
								group_bank[g].pickup_threshold <= THRESHOLD_MAX;
							end else begin
								group_bank[g].pickup_threshold <= reg_wdata_i[15:0];
							end
						end
						REG_SECTOR_HALF: begin
							if (reg_wdata_i[11:0] < SECTOR_MIN) begin
								group_bank[g].sector_half <= SECTOR_MIN;
							end else if (reg_wdata_i[11:0] > SECTOR_MAX) begin
								group_bank[g].sector_half <= SECTOR_MAX;
							end else begin
								group_bank[g].sector_half <= reg_wdata_i[11:0];
							end
						end
						REG_SECTOR_CENTER: begin
							if ($signed(reg_wdata_i[11:0]) < CENTER_MIN) begin
								group_bank[g].sector_center <= CENTER_MIN;
							end else if ($signed(reg_wdata_i[11:0]) > CENTER_MAX) begin
								group_bank[g].sector_center <= CENTER_MAX;
							end else begin
								group_bank[g].sector_center <= reg_wdata_i[11:0];
							end
						end
						REG_OPERATE_DELAY: group_bank[g].operate_delay <= reg_wdata_i[15:0];
						default: ;
					endcase
				end
			end
		end
	endgenerate

	// active group follows the selector while running
	assign active = group_bank[setting_group_i];
	// pick-up comparison per phase
	generate
		for (genvar p = 0; p < 3; p++) begin : g_phase
			logic [15:0] mag;
			logic [23:0] scaled_mag;
			logic [23:0] release_level;
			assign mag = pick_mag(meas, mag_select, p);
			assign scaled_mag = 24'(mag) * 24'(FULL_PCT);
			assign release_level = 24'(active.pickup_threshold) * 24'(RESET_RATIO_PCT);
			assign above[p] = mag > active.pickup_threshold;
			assign released[p] = scaled_mag < release_level;
		end
	endgenerate
	// pick-up with built-in release ratio
	assign next_picked = picked ? !(&released) : (|above);
	// reference and current angle selection
	always_comb begin
		voltage_lost = meas.positive_sequence_voltage < VOLTAGE_LOSS_LEVEL;
		live_ref = meas.voltage_angle;
		cur_angle = meas.current_angle;
		if (meas.line_to_line_voltage_mode && !meas.residual_voltage_present && meas.single_phase_fault) begin
			live_ref = meas.healthy_ll_angle;
			cur_angle = meas.faulty_phase_angle;
		end
		ref_angle = live_ref;
		if (voltage_lost) begin
			ref_angle = using_memory_now() ? history[hist_ptr] : 12'sh000;
		end
		if (meas.line_to_line_voltage_mode && !meas.residual_voltage_present && meas.short_circuit) begin
			next_angle = meas.impedance_angle;
		end else begin
			next_angle = wrap_angle(14'(cur_angle) - 14'(ref_angle));
		end
		sector_dist = abs_angle(wrap_angle(14'(next_angle) - 14'(active.sector_center)));
		if (in_sector) begin
			next_in_sector = sector_dist <= 14'(active.sector_half) + SECTOR_HYSTERESIS;
		end else begin
			next_in_sector = sector_dist <= 14'(active.sector_half);
		end
		qualified = next_picked && (!directional || next_in_sector);
	end

	// memory still valid in this cycle
	function automatic logic using_memory_now();
		return mem_ticks < 8'(MEMORY_HOLD_TICKS);
	endfunction : using_memory_now

	// angle history, frozen once voltage is lost or a fault is picked up
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < HISTORY_TICKS; i++) begin
				history[i] <= 12'sh000;
			end
			hist_ptr <= '0;
		end else if (tick && !voltage_lost && !picked && !next_picked) begin
			history[hist_ptr] <= live_ref;
			hist_ptr <= (hist_ptr == 5'(HISTORY_TICKS - 1)) ? 5'h00 : hist_ptr + 1'b1;
		end
	end

	// voltage memory timer
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			mem_ticks <= '0;
			using_memory <= 1'b0;
			angle_zeroed <= 1'b0;
		end else if (tick) begin
			if (!voltage_lost) begin
				mem_ticks <= '0;
				using_memory <= 1'b0;
				angle_zeroed <= 1'b0;
			end else begin
				if (using_memory_now()) begin
					mem_ticks <= mem_ticks + 1'b1;
				end
				using_memory <= using_memory_now();
				angle_zeroed <= !using_memory_now();
			end
		end
	end

	// stage evaluation once per program cycle
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			picked <= 1'b0;
			in_sector <= 1'b0;
			start <= 1'b0;
			trip <= 1'b0;
			blocked <= 1'b0;
			delay_count <= '0;
			operating_angle <= 12'sh000;
		end else if (tick) begin
			picked <= next_picked;
			in_sector <= next_in_sector;
			operating_angle <= next_angle;
			if (qualified && !block_i) begin
				start <= 1'b1;
				blocked <= 1'b0;
				if (delay_count >= active.operate_delay) begin
					trip <= 1'b1;
				end else begin
					delay_count <= delay_count + 1'b1;
				end
			end else if (qualified && block_i) begin
				start <= 1'b0;
				trip <= 1'b0;
				blocked <= 1'b1;
				delay_count <= '0;
			end else begin
				start <= 1'b0;
				trip <= 1'b0;
				blocked <= 1'b0;
				delay_count <= '0;
			end
		end
	end

	// outputs, with forced status while forcing is enabled
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			stage_o <= '0;
			program_tick_o <= 1'b0;
		end else begin
			program_tick_o <= tick;
			if (stage_forcing_enable_i) begin
				case (force_select)
					FORCE_START: stage_o <= '{start: 1'b1, trip: 1'b0, blocked: 1'b0};
					FORCE_TRIP: stage_o <= '{start: 1'b1, trip: 1'b1, blocked: 1'b0};
					FORCE_BLOCKED: stage_o <= '{start: 1'b0, trip: 1'b0, blocked: 1'b1};
					default: stage_o <= '{start: start, trip: trip, blocked: blocked};
				endcase
			end else begin
				stage_o <= '{start: start, trip: trip, blocked: blocked};
			end
		end
	end

	// register read, data in the cycle after the strobe only
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= '0;
		end else if (!reg_read_i) begin
			reg_rdata_o <= '0;
		end else if (reg_addr_i == REG_CONTROL) begin
			reg_rdata_o <= {27'h000_0000, force_select, mag_select, directional};
		end else if (reg_addr_i == REG_STATUS) begin
			reg_rdata_o <= {24'h00_0000, angle_zeroed, using_memory, in_sector, picked, blocked, trip, start, setting_group_i};
		end else if (reg_addr_i == REG_ANGLE) begin
			reg_rdata_o <= 32'(operating_angle);
		end else if (group_hit) begin
			case (8'(group_off[3:0]))
				REG_THRESHOLD: reg_rdata_o <= {16'h0000, group_bank[group_wsel].pickup_threshold};
				REG_SECTOR_HALF: reg_rdata_o <= {20'h0_0000, group_bank[group_wsel].sector_half};
				REG_SECTOR_CENTER: reg_rdata_o <= 32'(group_bank[group_wsel].sector_center);
				REG_OPERATE_DELAY: reg_rdata_o <= {16'h0000, group_bank[group_wsel].operate_delay};
				default: reg_rdata_o <= '0;
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end
endmodule : dir_oc_stage

// ==== dir_oc_stage_properties.sv ====
// port checker for the directional overcurrent stage
`timescale 1ns/1ps
module dir_oc_stage_properties import dir_oc_pkg::*; #(
	parameter int CYCLE_CLKS = PROGRAM_CYCLE_CLKS
) (
	// watched ports
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic reg_read_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic block_i,
	input wire logic stage_forcing_enable_i,
	input wire logic setting_group_i,
	input wire stage_out_t stage_o,
	input wire logic program_tick_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	logic [31:0] gap;
	logic seen;
	// cycles since the last program tick
	always_ff @(posedge clock_i) begin
		if (!reset_n_i || program_tick_o) begin
			gap <= 32'h0000_0000;
		end else begin
			gap <= gap + 32'h0000_0001;
		end
	end
	// the first tick only arms the spacing check
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			seen <= 1'b0;
		end else if (program_tick_o) begin
			seen <= 1'b1;
		end
	end
	a_tick_spacing: assert property (program_tick_o && seen |-> gap == CYCLE_CLKS - 1)
		else $error("program tick spacing wrong");
	a_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0000_0000)
		else $error("read data not zero outside an answer");
	a_status_group: assert property ($past(reg_read_i) && $past(reg_addr_i) == REG_STATUS |->
		reg_rdata_o[0] == $past(setting_group_i) && reg_rdata_o[31:8] == 24'h00_0000)
		else $error("status does not show the active group");
	a_output_on_tick: assert property ($changed(stage_o) && !stage_forcing_enable_i && !$past(stage_forcing_enable_i)
		&& !$past(stage_forcing_enable_i, 2) && !$past(stage_forcing_enable_i, 3) |-> $past(program_tick_o))
		else $error("stage output moved between ticks");
	a_block_stops_start: assert property (program_tick_o && $past(block_i) && !stage_forcing_enable_i
		&& !$past(stage_forcing_enable_i) |=> !stage_o.start && !stage_o.trip)
		else $error("start or trip despite blocking");
	a_start_unblocked: assert property ($rose(stage_o.start) && !stage_forcing_enable_i
		&& !$past(stage_forcing_enable_i) && !$past(stage_forcing_enable_i, 2) |-> !$past(block_i, 2))
		else $error("start rose while blocked");
	a_trip_with_start: assert property (stage_o.trip |-> stage_o.start)
		else $error("trip without start");
	a_blocked_alone: assert property (stage_o.blocked |-> !stage_o.start && !stage_o.trip)
		else $error("blocked together with start or trip");
endmodule : dir_oc_stage_properties

bind dir_oc_stage dir_oc_stage_properties #(.CYCLE_CLKS(CYCLE_CLKS)) dir_oc_stage_properties_i (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_read_i(reg_read_i),
	.reg_rdata_o(reg_rdata_o), .block_i(block_i), .stage_forcing_enable_i(stage_forcing_enable_i),
	.setting_group_i(setting_group_i), .stage_o(stage_o), .program_tick_o(program_tick_o));

// ==== dir_oc_stage_test.sv ====
// self-checking bench for the directional overcurrent stage
`timescale 1ns/1ps
module dir_oc_stage_test import dir_oc_pkg::*; ;
	localparam int CYC = 20;
	logic clock_i, reset_n_i, reg_write_i, reg_read_i, block, force_en, group, meas_valid, program_tick_o;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	meas_t meas;
	stage_out_t stage_o;
	logic [1:0] ph, flt;
	logic [15:0] rms, trms, peak, volt;
	logic [11:0] vang, iang;
	int mismatches, n_checks;
	logic [15:0] a_lv [4] = '{16'h0079, 16'h0075, 16'h0074, 16'h0078};
	logic [2:0] a_ex [4] = '{3'h6, 3'h6, 3'h0, 3'h0};
	logic [11:0] c_cen [10] = '{0, 0, 0, 0, 0, 0, 12'hE3E, 12'hE3E, 0, 0};
	logic [11:0] c_va [10] = '{0, 0, 0, 0, 0, 12'h12C, 0, 0, 12'h12C, 12'h12C};
	logic [11:0] c_ia [10] = '{12'h320, 12'h37A, 12'h385, 12'h37A, 12'h370, 12'h44C, 12'hE5C, 12'h1F4, 12'h44C, 12'h3E8};
	logic [1:0] c_ff [10] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 2};
	logic [2:0] c_ex [10] = '{3'h6, 3'h6, 3'h0, 3'h0, 3'h6, 3'h6, 3'h6, 3'h0, 3'h6, 3'h6};
	logic [2:0] f_ex [4] = '{3'h0, 3'h4, 3'h6, 3'h1};

	dir_oc_stage #(.CYCLE_CLKS(CYC)) dir_oc_stage_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o), .meas_i(meas), .meas_valid_i(meas_valid), .block_i(block),
		.stage_forcing_enable_i(force_en), .setting_group_i(group), .stage_o(stage_o), .program_tick_o(program_tick_o));
	dir_oc_front_end dir_oc_front_end_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .program_tick_i(program_tick_o),
		.phase_i(ph), .rms_i(rms), .trms_i(trms), .peak_i(peak), .volt_i(volt), .vang_i(vang), .iang_i(iang),
		.fault_i(flt), .meas_o(meas), .meas_valid_o(meas_valid));

	// 25 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clock_i);
		reg_write_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge clock_i);
		reg_read_i <= 1'b0;
		#1 chk("register", exp, reg_rdata_o & mask);
	endtask : rd
	// wait for n evaluations, returning once the outputs have settled
	task automatic tick(input int n);
		int w;
		repeat (n) begin
			w = 0;
			do begin
				@(posedge clock_i);
				#1 w++;
			end while (program_tick_o !== 1'b1 && w < 4 * CYC);
			if (w >= 4 * CYC) chk("tick", 1, 0);
			@(posedge clock_i);
			#1;
		end
	endtask : tick
	task automatic step(input logic [2:0] e);
		tick(2);
		chk("stage", e, {stage_o.start, stage_o.trip, stage_o.blocked});
	endtask : step
	task automatic cur(input logic [1:0] p, input logic [15:0] r, t, k);
		@(posedge clock_i);
		ph <= p;
		rms <= r;
		trms <= t;
		peak <= k;
	endtask : cur
	task automatic ang(input logic [11:0] v, c, input logic [1:0] f);
		@(posedge clock_i);
		vang <= v;
		iang <= c;
		flt <= f;
	endtask : ang
	// watchdog
	initial begin
		#400_000;
		chk("watchdog", 0, 1);
		test_done();
	end
	// main sequence
	initial begin
		{reset_n_i, reg_write_i, reg_read_i, block, force_en, group, ph, flt} = '0;
		{reg_addr_i, reg_wdata_i, rms, trms, peak, vang} = '0;
		volt = 16'h2710;
		iang = 12'h708;
		repeat (3) @(posedge clock_i);
		reset_n_i <= 1'b1;
		rd(REG_CONTROL, 32'h0000_0001, 32'hFFFF_FFFF);
		rd(REG_GROUP_BASE + REG_THRESHOLD, 32'h0000_0078, 32'hFFFF_FFFF);
		rd(REG_GROUP_BASE + REG_SECTOR_HALF, 32'h0000_0370, 32'hFFFF_FFFF);
		rd(REG_GROUP_BASE + REG_SECTOR_CENTER, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(8'h30, 32'h0000_0000, 32'hFFFF_FFFF);
		$display("defaults test done");
		wr(REG_CONTROL, 32'h0000_0000);
		for (int p = 0; p < 3; p++) begin
			for (int k = 0; k < 4; k++) begin
				cur(2'(p), a_lv[k], 0, 0);
				step(a_ex[k]);
			end
		end
		$display("pick-up test done");
		for (int m = 0; m < 3; m++) begin
			wr(REG_CONTROL, 32'(m * 2));
			cur(0, (m == 0) ? 16'h00C8 : 0, (m == 1) ? 16'h00C8 : 0, (m == 2) ? 16'h00C8 : 0);
			step(3'h6);
			wr(REG_CONTROL, 32'(((m + 1) % 3) * 2));
			step(3'h0);
		end
		$display("magnitude test done");
		wr(REG_GROUP_BASE + REG_SECTOR_HALF, 32'h0000_07D0);
		rd(REG_GROUP_BASE + REG_SECTOR_HALF, 32'h0000_06A4, 32'hFFFF_FFFF);
		wr(REG_GROUP_BASE + REG_SECTOR_HALF, 32'h0000_0370);
		wr(REG_GROUP_BASE + REG_THRESHOLD, 32'h0000_0005);
		rd(REG_GROUP_BASE + REG_THRESHOLD, 32'h0000_000A, 32'hFFFF_FFFF);
		wr(REG_GROUP_BASE + REG_THRESHOLD, 32'h0000_0078);
		wr(REG_CONTROL, 32'h0000_0001);
		cur(0, 16'h00C8, 0, 0);
		for (int k = 0; k < 10; k++) begin
			wr(REG_GROUP_BASE + REG_SECTOR_CENTER, {20'h0_0000, c_cen[k]});
			ang(c_va[k], c_ia[k], c_ff[k]);
			step(c_ex[k]);
			if (k == 6) rd(REG_ANGLE, 32'hFFFF_FE5C, 32'hFFFF_FFFF);
		end
		rd(REG_ANGLE, 32'h0000_02BC, 32'hFFFF_FFFF);
		$display("sector test done");
		wr(REG_GROUP_BASE + REG_GROUP_STRIDE + REG_THRESHOLD, 32'h0000_012C);
		wr(REG_CONTROL, 32'h0000_0000);
		@(posedge clock_i);
		group <= 1'b1;
		step(3'h0);
		rd(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
		rd(REG_CONTROL, 32'h0000_0000, 32'hFFFF_FFFF);
		@(posedge clock_i);
		group <= 1'b0;
		step(3'h6);
		$display("group test done");
		wr(REG_GROUP_BASE + REG_OPERATE_DELAY, 32'h0000_0003);
		rd(REG_GROUP_BASE + REG_OPERATE_DELAY, 32'h0000_0003, 32'hFFFF_FFFF);
		cur(0, 0, 0, 0);
		step(3'h0);
		cur(0, 16'h00C8, 0, 0);
		step(3'h4);
		tick(2);
		chk("stage", 3'h4, {stage_o.start, stage_o.trip, stage_o.blocked});
		tick(1);
		chk("stage", 3'h6, {stage_o.start, stage_o.trip, stage_o.blocked});
		@(posedge clock_i);
		block <= 1'b1;
		tick(1);
		chk("stage", 3'h1, {stage_o.start, stage_o.trip, stage_o.blocked});
		@(posedge clock_i);
		block <= 1'b0;
		tick(1);
		chk("stage", 3'h4, {stage_o.start, stage_o.trip, stage_o.blocked});
		tick(3);
		chk("stage", 3'h6, {stage_o.start, stage_o.trip, stage_o.blocked});
		cur(0, 0, 0, 0);
		step(3'h0);
		wr(REG_GROUP_BASE + REG_OPERATE_DELAY, 32'h0000_0000);
		$display("timing test done");
		wr(REG_CONTROL, 32'h0000_0010);
		step(3'h0);
		@(posedge clock_i);
		force_en <= 1'b1;
		for (int f = 0; f < 4; f++) begin
			wr(REG_CONTROL, 32'(f * 8));
			repeat (2) @(posedge clock_i);
			#1 chk("forced", f_ex[f], {stage_o.start, stage_o.trip, stage_o.blocked});
		end
		@(posedge clock_i);
		force_en <= 1'b0;
		wr(REG_CONTROL, 32'h0000_0001);
		$display("force test done");
		ang(12'h12C, 12'hDDA, 0);
		tick(25);
		ang(12'h258, 12'hDDA, 0);
		tick(10);
		@(posedge clock_i);
		volt <= 16'h0032;
		cur(0, 16'h00C8, 0, 0);
		ang(12'hA24, 12'hDDA, 0);
		step(3'h6);
		rd(REG_STATUS, 32'h0000_0040, 32'h0000_00C0);
		tick(95);
		rd(REG_STATUS, 32'h0000_0040, 32'h0000_00C0);
		tick(4);
		rd(REG_STATUS, 32'h0000_0040, 32'h0000_00C0);
		tick(1);
		rd(REG_STATUS, 32'h0000_0080, 32'h0000_00C0);
		ang(12'h258, 12'hCE0, 0);
		step(3'h6);
		$display("memory test done");
		test_done();
	end
endmodule : dir_oc_stage_test
